// ---- rtp_pkg.sv ----
`default_nettype none
package rtp_pkg;
  localparam int           ADDR_W          = 12;
  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [7:0]   IDX_MODE        = 8'hA8;
  localparam logic [7:0]   IDX_COUNT       = 8'hA9;
  localparam logic [7:0]   IDX_RELOAD      = 8'hAA;
  localparam logic [7:0]   IDX_DUTY        = 8'hAB;
  localparam logic [7:0]   IDX_CTRL        = 8'hAC;
  localparam logic [7:0]   IDX_CHAN        = 8'hAD;
  localparam logic [7:0]   IDX_EXT         = 8'hAE;
  // Mode register fields.
  localparam int           MODE_RUN_BIT    = 7;
  localparam int           MODE_RATE_LSB   = 4;
  localparam int           MODE_SINGLE_BIT = 1;
  localparam int           MODE_PWMEN_BIT  = 0;
  localparam logic [7:0]   MODE_RESET      = 8'h00;
  // Control register fields.
  localparam int           CTRL_FLAG_BIT   = 0;
  localparam int           CTRL_IRQEN_BIT  = 1;
  localparam int           CTRL_CLKSRC_BIT = 2;
  localparam int           CTRL_EVENT_BIT  = 3;
  // Channel and extension fields sit at bits 5:4.
  localparam int           CHAN_LSB        = 4;
  localparam logic [7:0]   COUNT_FULL      = 8'hFF;
  localparam logic [7:0]   BYTE_RESET      = 8'h00;
  localparam logic [6:0]   PRESCALE_MASK   = 7'h7F;
  localparam logic [15:0]  IRQ_VECTOR      = 16'h0008;
endpackage
`default_nettype wire

// ---- rtp_sync_edge.sv ----
`default_nettype none
module rtp_sync_edge
  import rtp_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      rise_out
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Only the second and third stages feed the edge detector.
  assign rise_out = stage2 & ~stage3;
endmodule
`default_nettype wire

// ---- rtp_prescaler.sv ----
`default_nettype none
module rtp_prescaler
  import rtp_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       clear_in,
  input  wire logic       src_tick_in,
  input  wire logic [2:0] code_in,
  output logic            tick_out
);
  logic [6:0] div_count;
  logic [6:0] mask;

  // Code 0 divides by 128 and each higher code halves the divisor.
  assign mask     = PRESCALE_MASK >> code_in;
  assign tick_out = src_tick_in && ((div_count & mask) == mask);

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div_count <= 7'h00;
    end else if (clear_in) begin
      div_count <= 7'h00;
    end else if (src_tick_in) begin
      div_count <= div_count + 7'h01;
    end
  end
endmodule
`default_nettype wire

// ---- rtp_timer.sv ----
// The APB interface to the registers is this design's own decision.
`default_nettype none
// How it works
// - Eight-bit up counter, one step per tick.
// - Run bit seven stops or starts counting.
// - Overflow at FF sets sticky flag.
// - Every overflow reloads counter from reload buffer.
// - Reload writes while running wait for overflow.
// - Enabled overflow requests interrupt at vector 0008H.
// - Clock source bit picks fast or slow.
// - Prescale code 000 divides 128, 111 by 1.
// - Output enable bit hands pins to PWM.
// - Single-pulse bit selects one-pulse PWM.
// - One pulse ends: flag set, enable cleared.
// - One-pulse mode ignores the extension option.
// - Two channels, each with its own select bit.
// - Four-phase extension per channel, own field.
// - Green mode keeps running, never wakes system.
// - Event mode counts external input edges.
// - PWM high from overflow until count equals duty.
module rtp_timer
  import rtp_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              low_osc_in,
  input  wire logic              event_in,
  input  wire logic              green_mode_in,
  input  wire logic [1:0]        gpio_level_in,
  output logic      [1:0]        pin_level_out,
  output logic      [1:0]        pin_pwm_owned_out,
  output logic                   overflow_irq_out,
  output logic      [15:0]       irq_vector_out,
  output logic                   wakeup_out
);
  logic       timer_run;
  logic [2:0] prescale_select;
  logic       single_pulse_select;
  logic       pwm_out_enable;
  logic       overflow_flag;
  logic       overflow_irq_enable;
  logic       clock_source_select;
  logic       event_count_mode;
  logic [1:0] channel_pin_select;
  logic [1:0] extension_select;
  logic [7:0] count_value;
  logic [7:0] reload_buffer;
  logic [7:0] reload_value;
  logic [7:0] duty_value;
  logic       pwm_wave;
  logic       wave_now;
  logic [1:0] ext_phase;

  logic       low_osc_rise;
  logic       event_rise;
  logic       src_tick;
  logic       count_tick;
  logic       overflow;
  logic       wr_en;
  logic       setup;
  logic       addr_ok;
  logic [7:0] index;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic       one_pulse_end;
  logic [1:0] ext_active;
  logic [1:0] next_pin_owned;
  logic [1:0] next_pin_level;

  rtp_sync_edge u_low_osc_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in (low_osc_in),
    .rise_out (low_osc_rise)
  );

  rtp_sync_edge u_event_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in (event_in),
    .rise_out (event_rise)
  );

  // The fast oscillator is the system clock itself, so it ticks every cycle.
  always_comb begin
    if (event_count_mode) begin
      src_tick = event_rise;
    end else if (clock_source_select) begin
      src_tick = low_osc_rise;
    end else begin
      src_tick = 1'b1;
    end
  end

  // Clearing while stopped gives every run the same first tick position.
  rtp_prescaler u_prescaler (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .clear_in    (!timer_run),
    .src_tick_in (src_tick),
    .code_in     (prescale_select),
    .tick_out    (count_tick)
  );

  // Green mode is only observed; the block carries on unchanged inside it.
  assign wakeup_out = 1'b0;

  assign overflow = timer_run && count_tick && (count_value == COUNT_FULL);
  assign one_pulse_end = overflow && single_pulse_select && pwm_out_enable;

  // APB decode: zero wait states, read data captured in the setup cycle.
  assign index   = paddr[ADDR_W-3:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:ADDR_W-2] == 2'b00) &&
                   (index >= IDX_MODE) && (index <= IDX_EXT);
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign wbyte   = pwdata[7:0];
  assign pready  = 1'b1;

  always_comb begin
    case (index)
      IDX_MODE:   rd_byte = {timer_run, prescale_select, 2'b00,
                             single_pulse_select, pwm_out_enable};
      IDX_COUNT:  rd_byte = count_value;
      IDX_DUTY:   rd_byte = duty_value;
      IDX_CTRL:   rd_byte = {4'h0, event_count_mode, clock_source_select,
                             overflow_irq_enable, overflow_flag};
      IDX_CHAN:   rd_byte = {2'b00, channel_pin_select, 4'h0};
      IDX_EXT:    rd_byte = {2'b00, extension_select, 4'h0};
      default:    rd_byte = BYTE_RESET;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= addr_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= !addr_ok;
    end
  end

  // Mode register; the one-pulse end clears the output enable over any write.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      timer_run           <= MODE_RESET[MODE_RUN_BIT];
      prescale_select     <= MODE_RESET[MODE_RATE_LSB +: 3];
      single_pulse_select <= MODE_RESET[MODE_SINGLE_BIT];
      pwm_out_enable      <= MODE_RESET[MODE_PWMEN_BIT];
    end else begin
      if (wr_en && index == IDX_MODE) begin
        timer_run           <= wbyte[MODE_RUN_BIT];
        prescale_select     <= wbyte[MODE_RATE_LSB +: 3];
        single_pulse_select <= wbyte[MODE_SINGLE_BIT];
        pwm_out_enable      <= wbyte[MODE_PWMEN_BIT];
      end
      if (one_pulse_end) begin
        pwm_out_enable <= 1'b0;
      end
    end
  end

  // Control fields; a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_flag       <= 1'b0;
      overflow_irq_enable <= 1'b0;
      clock_source_select <= 1'b0;
      event_count_mode    <= 1'b0;
    end else begin
      if (wr_en && index == IDX_CTRL) begin
        overflow_flag       <= wbyte[CTRL_FLAG_BIT] | overflow;
        overflow_irq_enable <= wbyte[CTRL_IRQEN_BIT];
        clock_source_select <= wbyte[CTRL_CLKSRC_BIT];
        event_count_mode    <= wbyte[CTRL_EVENT_BIT];
      end else if (overflow) begin
        overflow_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      channel_pin_select <= 2'b00;
      extension_select   <= 2'b00;
      duty_value         <= BYTE_RESET;
    end else if (wr_en) begin
      if (index == IDX_CHAN) begin
        channel_pin_select <= wbyte[CHAN_LSB +: 2];
      end
      if (index == IDX_EXT) begin
        extension_select <= wbyte[CHAN_LSB +: 2];
      end
      if (index == IDX_DUTY) begin
        duty_value <= wbyte;
      end
    end
  end

  // Double-buffered reload: while stopped a write reaches both stages at once.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reload_buffer <= BYTE_RESET;
      reload_value  <= BYTE_RESET;
    end else begin
      if (wr_en && index == IDX_RELOAD) begin
        reload_buffer <= wbyte;
        if (!timer_run) begin
          reload_value <= wbyte;
        end
      end
      if (overflow) begin
        reload_value <= reload_buffer;
      end
    end
  end

  // Counter; a software write to the count wins only when no overflow is due.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count_value <= BYTE_RESET;
    end else if (overflow) begin
      // Loading the buffer lets a new period start at the very next overflow.
      count_value <= reload_buffer;
    end else if (wr_en && index == IDX_COUNT) begin
      count_value <= wbyte;
    end else if (timer_run && count_tick) begin
      count_value <= count_value + 8'h01;
    end
  end

  // Waveform starts high, falls on duty match and rises again at overflow.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_wave  <= 1'b1;
      ext_phase <= 2'b00;
    end else if (!timer_run) begin
      pwm_wave  <= 1'b1;
      ext_phase <= 2'b00;
    end else if (overflow) begin
      pwm_wave  <= 1'b1;
      ext_phase <= ext_phase + 2'b01;
    end else if (count_value == duty_value) begin
      pwm_wave <= 1'b0;
    end
  end

  // The live compare masks the wave, as the register alone would stay high one clock too long.
  assign wave_now = pwm_wave && (count_value != duty_value);

  // An extended channel carries the wave only in its own quarter of four periods.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      assign ext_active[ch] = extension_select[ch] && !single_pulse_select;
      assign next_pin_owned[ch] = timer_run && pwm_out_enable && channel_pin_select[ch];
      assign next_pin_level[ch] = !next_pin_owned[ch] ? gpio_level_in[ch] :
                                  !ext_active[ch] ? wave_now :
                                  (ext_phase == 2'(2 * ch)) && wave_now;
    end
  endgenerate

  // Released pins fall back to the GPIO level, which keeps its last state.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_level_out     <= 2'b00;
      pin_pwm_owned_out <= 2'b00;
    end else begin
      pin_level_out     <= next_pin_level;
      pin_pwm_owned_out <= next_pin_owned;
    end
  end

  assign overflow_irq_out = overflow_flag && overflow_irq_enable;
  assign irq_vector_out   = IRQ_VECTOR;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  logic cnt_wr;
  assign cnt_wr = wr_en && index == IDX_COUNT;

  property p_count_step;
    timer_run && count_tick && !overflow && !cnt_wr |=>
      count_value == $past(count_value) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step");

  property p_stopped_hold;
    !timer_run && !cnt_wr |=> $stable(count_value);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped count moved");

  property p_flag_set;
    overflow |=> overflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

  property p_reload;
    overflow |=> count_value == $past(reload_buffer);
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_buffer_hold;
    timer_run && !overflow && wr_en && index == IDX_RELOAD |=> $stable(reload_value);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("reload took effect early");

  property p_irq;
    overflow && overflow_irq_enable && !wr_en |=> overflow_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_fast_div1;
    timer_run && prescale_select == 3'b111 && !clock_source_select && !event_count_mode
      |-> count_tick;
  endproperty
  a_fast_div1: assert property (p_fast_div1) else $error("divide by one missed a tick");

  property p_one_pulse;
    one_pulse_end |=> !pwm_out_enable && overflow_flag ##1 pin_pwm_owned_out == 2'b00;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("one pulse did not end");

  property p_no_ext;
    single_pulse_select |-> ext_active == 2'b00;
  endproperty
  a_no_ext: assert property (p_no_ext) else $error("extension in one-pulse mode");

  property p_no_wake;
    green_mode_in |-> !wakeup_out;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake-up raised");

  property p_wave_high;
    overflow |=> pwm_wave;
  endproperty
  a_wave_high: assert property (p_wave_high) else $error("wave not high after overflow");

  c_overflow:  cover property (overflow && overflow_irq_enable);
  c_one_pulse: cover property (one_pulse_end);
  c_duty_fall: cover property (timer_run && pwm_wave ##1 !pwm_wave);
  c_event:     cover property (event_count_mode && count_tick);
endmodule
`default_nettype wire

// ---- rtp_pin_partner.sv ----
`default_nettype none
module rtp_pin_partner (
  input  wire logic       clock_in,
  input  wire logic       slow_on_in,
  output logic      [1:0] gpio_out,
  output logic            low_osc_out,
  output logic            event_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  initial begin
    gpio_out = 2'h0;
    low_osc_out = 1'h0;
    event_out = 1'h0;
  end
  // The slow oscillator runs at a tenth of the clock and rests low while unused.
  always @(posedge clock_in) begin
    ph <= (ph == 9) ? 0 : ph + 1;
    low_osc_out <= slow_on_in && ph < 5;
  end
  task automatic pulse_events(input int cnt);
    repeat (cnt) begin
      @(posedge clock_in) event_out <= 1'h1;
      repeat (2) @(posedge clock_in);
      event_out <= 1'h0;
      repeat (2) @(posedge clock_in);
    end
  endtask
  task automatic set_gpio(input logic [1:0] v);
    @(posedge clock_in) gpio_out <= v;
  endtask
endmodule
`default_nettype wire

// ---- eight_bit_reload_timer_pwm_bench.sv ----
`default_nettype none
module eight_bit_reload_timer_pwm_bench;
  import rtp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock_in = 1'h0;
  logic              rst_in = 1'h1;
  logic              psel = 1'h0;
  logic              penable = 1'h0;
  logic              pwrite = 1'h0;
  logic              green = 1'h0;
  logic              slow_on = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready, pslverr, low_osc, ev, wake, irq, perr;
  logic [1:0]        gpio, pin, owned;
  logic [15:0]       vec;
  logic [7:0]        rd, duty;
  int                err_count = 0;
  int                check_count = 0;
  int                cycles = 0;
  int                seed = 31;
  int                n, hi0, hi1;
  always #5 clock_in = ~clock_in;
  rtp_timer dut (.clock_in(clock_in), .rst_in(rst_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_osc_in(low_osc), .event_in(ev), .green_mode_in(green),
    .gpio_level_in(gpio), .pin_level_out(pin), .pin_pwm_owned_out(owned),
    .overflow_irq_out(irq), .irq_vector_out(vec), .wakeup_out(wake));
  rtp_pin_partner partner (.clock_in(clock_in), .slow_on_in(slow_on), .gpio_out(gpio),
    .low_osc_out(low_osc), .event_out(ev));
  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // A hang costs a mismatch, so a stuck design can never pass.
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input int tol);
    chk(got, (got <= exp + tol && got + tol >= exp) ? got : exp);
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clock_in);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clock_in);
    penable <= 1'h1;
    do @(posedge clock_in); while (pready !== 1'h1);
    rd = prdata[7:0];
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'h1, idx, v);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    chk({perr, rd}, {1'h0, exp});
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'h1 && n < 3000) begin
      @(posedge clock_in);
      #1;
      n++;
    end
  endtask
  task automatic count_high(input int len);
    hi0 = 0;
    hi1 = 0;
    repeat (len) begin
      @(posedge clock_in);
      #1;
      hi0 += int'(owned[0] & pin[0]);
      hi1 += int'(owned[1] & pin[1]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'h0;
    green <= 1'($random(seed));
    rdchk(IDX_MODE, MODE_RESET);
    rdchk(IDX_COUNT, 8'h00);
    rdchk(IDX_CTRL, 8'h00);
    wr(IDX_MODE, 8'h7E);
    rdchk(IDX_MODE, 8'h72);
    apb(1'h0, 8'h10, 8'h00);
    chk({perr, rd}, 9'h100);
    wr(IDX_COUNT, 8'h55);
    repeat (20) @(posedge clock_in);
    rdchk(IDX_COUNT, 8'h55);
    wr(IDX_CTRL, 8'h02);
    wr(IDX_COUNT, 8'hFE);
    wr(IDX_RELOAD, 8'hFE);
    wr(IDX_MODE, 8'h80);
    wr(IDX_RELOAD, 8'hFD);
    wait_irq();
    near(n, 256, 140);
    rdchk(IDX_COUNT, 8'hFD);
    chk(vec, IRQ_VECTOR);
    repeat (200) @(posedge clock_in);
    rdchk(IDX_CTRL, 8'h03);
    wr(IDX_MODE, 8'h00);
    wr(IDX_CTRL, 8'h01);
    #1;
    chk(irq, 1'h0);
    wr(IDX_CTRL, 8'h02);
    rdchk(IDX_CTRL, 8'h02);
    for (int c = 1; c < 8; c++) begin
      wr(IDX_COUNT, 8'hF0);
      wr(IDX_RELOAD, 8'hF0);
      wr(IDX_MODE, {1'h1, c[2:0], 4'h0});
      wait_irq();
      near(n, 16 * (128 >> c), (128 >> c) + 8);
      wr(IDX_MODE, 8'h00);
      wr(IDX_CTRL, 8'h02);
    end
    slow_on <= 1'h1;
    wr(IDX_CTRL, 8'h06);
    wr(IDX_COUNT, 8'hFE);
    wr(IDX_RELOAD, 8'hFE);
    wr(IDX_MODE, 8'hF0);
    wait_irq();
    near(n, 19, 11);
    wr(IDX_MODE, 8'h00);
    slow_on <= 1'h0;
    wr(IDX_CTRL, 8'h08);
    wr(IDX_COUNT, 8'h10);
    wr(IDX_RELOAD, 8'h10);
    wr(IDX_MODE, 8'hF0);
    partner.pulse_events(5);
    repeat (10) @(posedge clock_in);
    rdchk(IDX_COUNT, 8'h15);
    wr(IDX_MODE, 8'h00);
    wr(IDX_CTRL, 8'h00);
    // Pins start out as general purpose, so the owned level is the only proof of the wave.
    partner.set_gpio(2'($random(seed)));
    duty = 8'hF1 + 8'($random(seed) & 7);
    wr(IDX_COUNT, 8'hF0);
    wr(IDX_RELOAD, 8'hF0);
    wr(IDX_DUTY, duty);
    wr(IDX_CHAN, 8'h10);
    wr(IDX_MODE, 8'hF1);
    repeat (40) @(posedge clock_in);
    count_high(16);
    chk(hi0, duty - 8'hF0);
    chk({owned, pin[1]}, {2'h1, gpio[1]});
    chk(wake, 1'h0);
    wr(IDX_CHAN, 8'h30);
    wr(IDX_EXT, 8'h10);
    repeat (40) @(posedge clock_in);
    count_high(64);
    chk(hi0, duty - 8'hF0);
    chk(hi1, 4 * (duty - 8'hF0));
    wr(IDX_MODE, 8'h00);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_COUNT, 8'hF0);
    wr(IDX_MODE, 8'hF3);
    count_high(30);
    near(hi0, duty - 8'hF0, 1);
    near(hi1, duty - 8'hF0, 1);
    rdchk(IDX_MODE, 8'hF2);
    rdchk(IDX_CTRL, 8'h01);
    chk(owned, 2'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
